// [core/sfr_bank1.sv]
// Second-bank special register map with an AHB-Lite slave port.
// Assumes RST is the power-on reset; brown-out and reset pin arrive asynchronously,
// the watchdog pulse and PC_INC come from logic on CLK_SYS.
`timescale 1ns/1ps
module sfr_bank1 (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic BROWN_OUT,
  input wire logic EXT_RESET_N,
  input wire logic WDT_TIMEOUT,
  input wire logic PC_INC,
  input wire logic [5:0] SERIAL_STATE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output wire sfr_pkg::cfg_t CFG,
  output logic [12:0] PROGRAM_COUNTER
);

  // Pin synchronisers: bit 1 brown-out, bit 0 reset pin (made active high)
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;

  always_ff @(posedge CLK_SYS) begin
    pin_s1_ff <= {BROWN_OUT, ~EXT_RESET_N};
    pin_s2_ff <= pin_s1_ff;
  end

  wire bor_lvl = pin_s2_ff[1];
  wire por_rst = RST | bor_lvl;
  // Only pin and watchdog count as non-power-up resets
  wire other_rst = ~por_rst & (pin_s2_ff[0] | WDT_TIMEOUT);
  wire wdt_evt = ~por_rst & WDT_TIMEOUT;
  wire any_rst = por_rst | other_rst;

  // Decode helpers
  function automatic logic is_mirror(input logic [7:0] ci);
    case (ci)
      sfr_pkg::IDX_INDIRECT, sfr_pkg::IDX_PC_LOW, sfr_pkg::IDX_STATUS,
      sfr_pkg::IDX_POINTER, sfr_pkg::IDX_PC_HOLD, sfr_pkg::IDX_INT_CTRL: is_mirror = 1'b1;
      default: is_mirror = 1'b0;
    endcase
  endfunction

  // The upper PC byte is deliberately absent from this list
  function automatic logic is_impl(input logic [7:0] ci);
    case (ci)
      sfr_pkg::IDX_INDIRECT, sfr_pkg::IDX_OPTION, sfr_pkg::IDX_PC_LOW, sfr_pkg::IDX_STATUS,
      sfr_pkg::IDX_POINTER, sfr_pkg::IDX_PORT_A_DIR, sfr_pkg::IDX_PORT_B_DIR,
      sfr_pkg::IDX_PORT_C_DIR, sfr_pkg::IDX_PC_HOLD, sfr_pkg::IDX_INT_CTRL,
      sfr_pkg::IDX_PERIPH_IE, sfr_pkg::IDX_RESET_CAUSE, sfr_pkg::IDX_PERIOD,
      sfr_pkg::IDX_SLAVE_ADDR,
      sfr_pkg::IDX_SERIAL_STATE, sfr_pkg::IDX_ANALOG_CFG: is_impl = 1'b1;
      default: is_impl = 1'b0;
    endcase
  endfunction

  // Returns {valid, bank-1 index}; bank-0 copies of core registers fold onto bank 1
  function automatic logic [8:0] canon(input logic [7:0] idx);
    logic [7:0] ci;
    ci = idx | sfr_pkg::BANK1_BASE;
    canon = {(idx[7] ? is_impl(idx) : is_mirror(ci)), ci};
  endfunction

  // Registers
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] int_ctrl_ff;
  logic [7:0] nxt_int_ctrl;
  logic [12:0] pc_ff;
  logic [12:0] nxt_pc;
  logic [1:0] cause_ff;
  logic [1:0] nxt_cause;
  logic [7:0] ptr_q;
  logic [4:0] pc_hold_q;
  logic [7:0] rd_val;
  logic [31:0] hrdata_ff;
  logic [7:0] tgt_ff;
  logic tgt_ok_ff;
  sfr_pkg::bus_state_t st_ff;
  sfr_pkg::bus_state_t nxt_st;

  // Address phase
  wire addr_ok = HSEL & HREADY & HTRANS[1];
  wire [7:0] bus_idx = HADDR[9:2];
  wire in_range = (HADDR[31:10] == 22'h000000) & (HADDR[1:0] == 2'h0);
  wire [8:0] dir_c = canon(bus_idx);
  wire [8:0] ind_c = canon(ptr_q);
  wire use_ind = dir_c[7:0] == sfr_pkg::IDX_INDIRECT;
  // Indirect access through the pointer; pointing back at itself reaches nothing
  wire ind_ok = ind_c[8] & (ind_c[7:0] != sfr_pkg::IDX_INDIRECT);
  wire tgt_ok = in_range & dir_c[8] & (~use_ind | ind_ok);
  wire [7:0] tgt = use_ind ? ind_c[7:0] : dir_c[7:0];

  always_comb begin
    nxt_st = sfr_pkg::ST_IDLE;
    case (st_ff)
      sfr_pkg::ST_READ_WAIT: nxt_st = sfr_pkg::ST_READ_OUT;
      sfr_pkg::ST_IDLE, sfr_pkg::ST_WRITE, sfr_pkg::ST_READ_OUT: begin
        if (addr_ok) begin
          nxt_st = HWRITE ? sfr_pkg::ST_WRITE : sfr_pkg::ST_READ_WAIT;
        end
      end
      default: nxt_st = sfr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_ff <= sfr_pkg::ST_IDLE;
      tgt_ff <= sfr_pkg::RST_ZERO8;
      tgt_ok_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (addr_ok) begin
        tgt_ff <= tgt;
        tgt_ok_ff <= tgt_ok;
      end
    end
  end

  // Reads take one wait state so read data always come from a flop
  assign HREADYOUT = st_ff != sfr_pkg::ST_READ_WAIT;
  assign HRESP = sfr_pkg::HRESP_OKAY;

  // Write commit in the data phase; a reset in the same cycle takes priority
  wire [7:0] wd = HWDATA[7:0];
  wire wr_commit = (st_ff == sfr_pkg::ST_WRITE) & tgt_ok_ff & ~any_rst;
  wire wr_option = wr_commit & (tgt_ff == sfr_pkg::IDX_OPTION);
  wire wr_pc_low = wr_commit & (tgt_ff == sfr_pkg::IDX_PC_LOW);
  wire wr_status = wr_commit & (tgt_ff == sfr_pkg::IDX_STATUS);
  wire wr_ptr = wr_commit & (tgt_ff == sfr_pkg::IDX_POINTER);
  wire wr_dir_a = wr_commit & (tgt_ff == sfr_pkg::IDX_PORT_A_DIR);
  wire wr_dir_b = wr_commit & (tgt_ff == sfr_pkg::IDX_PORT_B_DIR);
  wire wr_dir_c = wr_commit & (tgt_ff == sfr_pkg::IDX_PORT_C_DIR);
  wire wr_pc_hold = wr_commit & (tgt_ff == sfr_pkg::IDX_PC_HOLD);
  wire wr_int_ctrl = wr_commit & (tgt_ff == sfr_pkg::IDX_INT_CTRL);
  wire wr_periph_ie = wr_commit & (tgt_ff == sfr_pkg::IDX_PERIPH_IE);
  // Cause bits are software-set flags; any reset event wins over a write
  wire wr_cause = wr_commit & (tgt_ff == sfr_pkg::IDX_RESET_CAUSE);
  wire wr_period = wr_commit & (tgt_ff == sfr_pkg::IDX_PERIOD);
  wire wr_slave = wr_commit & (tgt_ff == sfr_pkg::IDX_SLAVE_ADDR);
  wire wr_analog = wr_commit & (tgt_ff == sfr_pkg::IDX_ANALOG_CFG);

  // Plain software registers; other resets force options, directions, period to ones
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_OPTION), .KEEP_ON_OTHER(1'b0))
    u_option (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_option),
              .wr_data(wd), .q(CFG.option));
  sfr_field_reg #(.WIDTH(sfr_pkg::PORT_A_W), .RESET_VALUE(sfr_pkg::RST_PORT_A_DIR),
                  .KEEP_ON_OTHER(1'b0))
    u_dir_a (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_dir_a),
             .wr_data(wd[sfr_pkg::PORT_A_W-1:0]), .q(CFG.port_a_dir));
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_PORT_DIR), .KEEP_ON_OTHER(1'b0))
    u_dir_b (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_dir_b),
             .wr_data(wd), .q(CFG.port_b_dir));
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_PORT_DIR), .KEEP_ON_OTHER(1'b0))
    u_dir_c (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_dir_c),
             .wr_data(wd), .q(CFG.port_c_dir));
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_PERIOD), .KEEP_ON_OTHER(1'b0))
    u_period (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_period),
              .wr_data(wd), .q(CFG.timer2_period));
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_ZERO8), .KEEP_ON_OTHER(1'b0))
    u_slave (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_slave),
             .wr_data(wd), .q(CFG.slave_address));
  // Unimplemented enable bits are dropped on write so they read back zero
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_ZERO8), .KEEP_ON_OTHER(1'b0))
    u_periph_ie (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_periph_ie),
                 .wr_data(wd & sfr_pkg::PERIPH_IE_MASK), .q(CFG.periph_ie));
  sfr_field_reg #(.WIDTH(sfr_pkg::ANALOG_W), .RESET_VALUE(sfr_pkg::RST_ANALOG),
                  .KEEP_ON_OTHER(1'b0))
    u_analog (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_analog),
              .wr_data(wd[sfr_pkg::ANALOG_W-1:0]), .q(CFG.analog_cfg));
  // The holding register only buffers; the counter moves on a low-byte write
  sfr_field_reg #(.WIDTH(sfr_pkg::PC_HOLD_W), .RESET_VALUE(sfr_pkg::RST_PC_HOLD),
                  .KEEP_ON_OTHER(1'b0))
    u_pc_hold (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_pc_hold),
               .wr_data(wd[sfr_pkg::PC_HOLD_W-1:0]), .q(pc_hold_q));
  // Pointer survives non-power-up resets
  sfr_field_reg #(.WIDTH(8), .RESET_VALUE(sfr_pkg::RST_ZERO8), .KEEP_ON_OTHER(1'b1))
    u_ptr (.clk(CLK_SYS), .por_rst(por_rst), .other_rst(other_rst), .wr_en(wr_ptr),
           .wr_data(wd), .q(ptr_q));

  // Status: TO/PD are hardware-owned; watchdog clears TO, pin reset leaves both
  wire nxt_to = wdt_evt ? 1'b0 : status_ff[sfr_pkg::ST_TO];
  wire nxt_pd = wdt_evt ? 1'b1 : status_ff[sfr_pkg::ST_PD];
  wire [7:0] status_other = (status_ff & sfr_pkg::STATUS_KEEP_MASK)
                          | {3'h0, nxt_to, nxt_pd, 3'h0};
  wire [7:0] status_wr = (wd & ~sfr_pkg::STATUS_RO_MASK)
                       | (status_ff & sfr_pkg::STATUS_RO_MASK);

  assign nxt_status = por_rst ? sfr_pkg::RST_STATUS_POR
                    : other_rst ? status_other
                    : wr_status ? status_wr : status_ff;
  // Interrupt control: bit 0 survives other resets
  assign nxt_int_ctrl = por_rst ? sfr_pkg::RST_ZERO8
                      : other_rst ? (int_ctrl_ff & sfr_pkg::INT_CTRL_KEEP_MASK)
                      : wr_int_ctrl ? wd : int_ctrl_ff;
  // A write to the low byte loads the whole counter: upper bits from the holding register, low byte from the written data
  assign nxt_pc = any_rst ? sfr_pkg::RST_PC
                : wr_pc_low ? {pc_hold_q, wd}
                : PC_INC ? pc_ff + 13'h0001 : pc_ff;
  // Power-on clears both cause bits; brown-out alone clears only its own
  assign nxt_cause = RST ? sfr_pkg::RST_CAUSE_POR
                   : bor_lvl ? {cause_ff[1], 1'b0}
                   : wr_cause ? wd[sfr_pkg::CAUSE_W-1:0] : cause_ff;

  always_ff @(posedge CLK_SYS) begin
    status_ff <= nxt_status;
    int_ctrl_ff <= nxt_int_ctrl;
    pc_ff <= nxt_pc;
    cause_ff <= nxt_cause;
  end

  assign CFG.int_control = int_ctrl_ff;
  assign CFG.status = status_ff;
  assign CFG.indirect_ptr = ptr_q;
  assign CFG.pc_upper_hold = pc_hold_q;
  assign PROGRAM_COUNTER = pc_ff;

  // Read mux; unlisted indices and unused bits give zero
  always_comb begin
    rd_val = sfr_pkg::RST_ZERO8;
    case (tgt_ff)
      sfr_pkg::IDX_OPTION: rd_val = CFG.option;
      sfr_pkg::IDX_PC_LOW: rd_val = pc_ff[7:0];
      sfr_pkg::IDX_STATUS: rd_val = status_ff;
      sfr_pkg::IDX_POINTER: rd_val = ptr_q;
      sfr_pkg::IDX_PORT_A_DIR: rd_val = {2'h0, CFG.port_a_dir};
      sfr_pkg::IDX_PORT_B_DIR: rd_val = CFG.port_b_dir;
      sfr_pkg::IDX_PORT_C_DIR: rd_val = CFG.port_c_dir;
      sfr_pkg::IDX_PC_HOLD: rd_val = {3'h0, pc_hold_q};
      sfr_pkg::IDX_INT_CTRL: rd_val = int_ctrl_ff;
      sfr_pkg::IDX_PERIPH_IE: rd_val = CFG.periph_ie;
      sfr_pkg::IDX_RESET_CAUSE: rd_val = {6'h00, cause_ff};
      sfr_pkg::IDX_PERIOD: rd_val = CFG.timer2_period;
      sfr_pkg::IDX_SLAVE_ADDR: rd_val = CFG.slave_address;
      sfr_pkg::IDX_SERIAL_STATE: rd_val = {2'h0, SERIAL_STATE};
      sfr_pkg::IDX_ANALOG_CFG: rd_val = {5'h00, CFG.analog_cfg};
      default: rd_val = sfr_pkg::RST_ZERO8;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hrdata_ff <= sfr_pkg::RD_ZERO;
    end else if (st_ff == sfr_pkg::ST_READ_WAIT) begin
      hrdata_ff <= tgt_ok_ff ? {sfr_pkg::RD_ZERO_PAD, rd_val} : sfr_pkg::RD_ZERO;
    end
  end

  assign HRDATA = hrdata_ff;

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_other_rst_ones: assert property (
    other_rst |=> (CFG.option == sfr_pkg::RST_OPTION) && (CFG.timer2_period == sfr_pkg::RST_PERIOD)
      && (CFG.port_a_dir == sfr_pkg::RST_PORT_A_DIR) && (CFG.port_b_dir == sfr_pkg::RST_PORT_DIR)
      && (CFG.port_c_dir == sfr_pkg::RST_PORT_DIR))
    else $error("other reset did not set options, directions and period to ones");

  a_status_other_rst: assert property (
    other_rst |=> ((status_ff & sfr_pkg::STATUS_CLR_MASK) == sfr_pkg::RST_ZERO8)
      && ((status_ff & sfr_pkg::STATUS_KEEP_MASK)
          == ($past(status_ff) & sfr_pkg::STATUS_KEEP_MASK)))
    else $error("status after other reset is wrong");

  a_wdt_timeout_flag: assert property (
    wdt_evt |=> !status_ff[sfr_pkg::ST_TO] && status_ff[sfr_pkg::ST_PD]
      && (CFG.indirect_ptr == $past(CFG.indirect_ptr)))
    else $error("watchdog reset handled as power-up reset");

  a_pin_rst_keeps: assert property (
    (other_rst && !WDT_TIMEOUT) |=> $stable(CFG.indirect_ptr)
      && (status_ff[sfr_pkg::ST_TO] == $past(status_ff[sfr_pkg::ST_TO])))
    else $error("pin reset lost pointer or timeout flag");

  a_pc_low_loads: assert property (
    wr_pc_low |=> pc_ff == {$past(pc_hold_q), $past(HWDATA[7:0])})
    else $error("program counter not loaded from holding register");

  a_pc_hold_no_jump: assert property (
    (wr_pc_hold && !PC_INC) |=> $stable(pc_ff))
    else $error("holding register write moved the program counter");

  a_unmapped_read_zero: assert property (
    (addr_ok && !HWRITE && !tgt_ok) |-> ##1 !HREADYOUT ##1 (HREADYOUT && HRDATA == sfr_pkg::RD_ZERO))
    else $error("unimplemented read did not return zero");

  a_mirror_read_same: assert property (
    (addr_ok && !HWRITE && in_range && !bus_idx[7] && is_mirror(bus_idx | sfr_pkg::BANK1_BASE)
      && bus_idx != (sfr_pkg::IDX_INDIRECT & ~sfr_pkg::BANK1_BASE))
      |-> tgt_ok && tgt == (bus_idx | sfr_pkg::BANK1_BASE))
    else $error("bank-0 copy did not reach the same register");

  a_unmapped_write_none: assert property (
    (st_ff == sfr_pkg::ST_WRITE && !tgt_ok_ff && !any_rst && !PC_INC)
      |=> $stable(CFG) && $stable(pc_ff) && $stable(cause_ff))
    else $error("write to unimplemented location changed state");

  // Bus timing as handed over: writes take no wait, reads exactly one
  a_read_one_wait: assert property (
    (st_ff == sfr_pkg::ST_READ_WAIT) |-> !HREADYOUT ##1 HREADYOUT)
    else $error("read did not take exactly one wait state");

  a_rdata_upper_zero: assert property (
    HRDATA[31:8] == sfr_pkg::RD_ZERO_PAD)
    else $error("unused read data bits not zero");

  a_bor_cause_clear: assert property (
    bor_lvl |=> !cause_ff[sfr_pkg::CAUSE_BOR])
    else $error("brown-out did not clear its cause bit");

  a_wdt_keeps_cause: assert property (
    wdt_evt |=> $stable(cause_ff))
    else $error("watchdog reset changed the reset cause bits");

  // Scenarios the bench is expected to reach
  c_pc_low_write: cover property (wr_pc_low);
  c_pin_reset: cover property (other_rst && !WDT_TIMEOUT);
  c_indirect_read: cover property (addr_ok && !HWRITE && use_ind && tgt_ok);
  c_wdt_reset: cover property (wdt_evt);
  c_mirror_write: cover property (addr_ok && HWRITE && tgt_ok && !bus_idx[7]);

endmodule // sfr_bank1

// [core/sfr_pkg.sv]
// Register map, reset values and shared types of the second-bank special registers.
// Assumes one 200 MHz clock; register indices are word indices on the bus (byte = 4 * index).
package sfr_pkg;

  // Register indices, also the decoded word index on the bus
  localparam logic [7:0] IDX_INDIRECT = 8'h80;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PC_LOW = 8'h82;
  localparam logic [7:0] IDX_STATUS = 8'h83;
  localparam logic [7:0] IDX_POINTER = 8'h84;
  localparam logic [7:0] IDX_PORT_A_DIR = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIR = 8'h86;
  localparam logic [7:0] IDX_PORT_C_DIR = 8'h87;
  localparam logic [7:0] IDX_PC_HOLD = 8'h8A;
  localparam logic [7:0] IDX_INT_CTRL = 8'h8B;
  localparam logic [7:0] IDX_PERIPH_IE = 8'h8C;
  localparam logic [7:0] IDX_RESET_CAUSE = 8'h8E;
  localparam logic [7:0] IDX_PERIOD = 8'h92;
  localparam logic [7:0] IDX_SLAVE_ADDR = 8'h93;
  localparam logic [7:0] IDX_SERIAL_STATE = 8'h94;
  localparam logic [7:0] IDX_ANALOG_CFG = 8'h9F;
  localparam logic [7:0] BANK1_BASE = 8'h80;

  // Widths
  localparam int PC_W = 13;
  localparam int PC_HOLD_W = 5;
  localparam int PORT_A_W = 6;
  localparam int SERIAL_STATE_W = 6;
  localparam int ANALOG_W = 3;
  localparam int CAUSE_W = 2;

  // Reset values
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [5:0] RST_PORT_A_DIR = 6'h3F;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [4:0] RST_PC_HOLD = 5'h00;
  localparam logic [2:0] RST_ANALOG = 3'h0;
  localparam logic [7:0] RST_STATUS_POR = 8'h18;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [1:0] RST_CAUSE_POR = 2'h0;

  // Field positions and masks
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;
  localparam logic [7:0] STATUS_CLR_MASK = 8'hE0;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h07;
  localparam logic [7:0] INT_CTRL_KEEP_MASK = 8'h01;
  localparam logic [7:0] PERIPH_IE_MASK = 8'h4F;
  localparam int CAUSE_BOR = 0;

  localparam logic [23:0] RD_ZERO_PAD = 24'h000000;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic [7:0] option;
    logic [5:0] port_a_dir;
    logic [7:0] port_b_dir;
    logic [7:0] port_c_dir;
    logic [7:0] timer2_period;
    logic [7:0] slave_address;
    logic [2:0] analog_cfg;
    logic [7:0] int_control;
    logic [7:0] periph_ie;
    logic [7:0] status;
    logic [7:0] indirect_ptr;
    logic [4:0] pc_upper_hold;
  } cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ_OUT} bus_state_t;

endpackage

// [core/sfr_field_reg.sv]
// One software register with power-up and other-reset values.
// Assumes resets and write strobe come from the same clock domain.
`timescale 1ns/1ps
module sfr_field_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter bit KEEP_ON_OTHER = 1'b0
) (
  input wire logic clk,
  input wire logic por_rst,
  input wire logic other_rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;
  wire load_reset = por_rst | (other_rst & ~KEEP_ON_OTHER);

  assign nxt_q = load_reset ? RESET_VALUE : (wr_en ? wr_data : q_ff);
  assign q = q_ff;

  always_ff @(posedge clk) begin
    q_ff <= nxt_q;
  end
endmodule // sfr_field_reg

// [dv/tb_top.sv]
// Self-checking bench for the second-bank special register map over AHB-Lite.
// Assumes sfr_bank1 answers writes with no wait and reads with one wait, as handed over.
`timescale 1ns/1ps
module tb_top;
  logic CLK_SYS, RST, BROWN_OUT, EXT_RESET_N, WDT_TIMEOUT, PC_INC;
  logic [5:0] SERIAL_STATE;
  logic HSEL, HWRITE, HREADYOUT, HRESP;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [12:0] PROGRAM_COUNTER;
  sfr_pkg::cfg_t CFG;
  wire logic HREADY;
  int err_total, checks;
  // Indices walked by the table checks; the last four are unmapped
  localparam logic [7:0] RI [20] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
    8'h87, 8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h92, 8'h93, 8'h94, 8'h9F, 8'h88, 8'h8D, 8'h95, 8'h9E};
  // Rows: power-up, all ones written, after watchdog, after brown-out
  localparam logic [7:0] EV [4][20] = '{
    '{8'h00, 8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hFF, 8'h00, 8'h2A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h00, 8'hFF, 8'h00, 8'h3F, 8'h00, 8'h3F, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h4F, 8'h03,
      8'hFF, 8'hFF, 8'h2A, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h00, 8'hFF, 8'h00, 8'h0D, 8'h55, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h03,
      8'hFF, 8'h00, 8'h2A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h00, 8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h02,
      8'hFF, 8'h00, 8'h2A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}};

  // The bus's hready is the one slave's hreadyout
  assign HREADY = HREADYOUT;

  sfr_bank1 uut (.CLK_SYS(CLK_SYS), .RST(RST), .BROWN_OUT(BROWN_OUT),
    .EXT_RESET_N(EXT_RESET_N), .WDT_TIMEOUT(WDT_TIMEOUT), .PC_INC(PC_INC),
    .SERIAL_STATE(SERIAL_STATE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .CFG(CFG),
    .PROGRAM_COUNTER(PROGRAM_COUNTER));

  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pc(input logic [12:0] exp);
    checks++;
    if (PROGRAM_COUNTER !== exp) begin
      err_total++;
      $display("mismatch program_counter expected %h seen %h", exp, PROGRAM_COUNTER);
    end
  endtask

  // The level seen at a falling edge is what the next rising edge samples
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      $display("mismatch hreadyout expected 1 seen %b", HREADYOUT);
    end
    d = HRDATA;
    @(posedge CLK_SYS);
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
      output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {22'h000000, idx, 2'b00};
    wait_rdy(q);
    HTRANS <= 2'b00;
    // Upper data bits carry junk that the slave must ignore
    HWDATA <= {24'hA5C3E1, d};
    wait_rdy(q);
    chk32("hresp", 32'h00000000, {31'h00000000, HRESP});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk32($sformatf("reg_%h", idx), {24'h000000, exp}, q);
  endtask

  task automatic rc_row(input int r);
    for (int i = 0; i < 20; i++) rc(RI[i], EV[r][i]);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  initial begin
    #50000;
    err_total++;
    end_of_test();
  end

  initial begin
    err_total = 0;
    checks = 0;
    RST = 1'b1;
    BROWN_OUT = 1'b0;
    EXT_RESET_N = 1'b1;
    WDT_TIMEOUT = 1'b0;
    PC_INC = 1'b0;
    SERIAL_STATE = 6'h2A;
    HSEL = 1'b0;
    HADDR = 32'h00000000;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'b010;
    HWDATA = 32'h00000000;
    cyc(12);
    RST <= 1'b0;
    cyc(1);
    rc_row(0);
    chk_pc(13'h0000);
    // Indirect, counter low byte and pointer are left out: they would move other state
    for (int i = 1; i < 20; i++) if (i != 2 && i != 3 && i != 4) wr(RI[i], 8'hFF);
    wr(8'h83, 8'h3F);
    rc_row(1);
    chk32("cfg_port_a_dir", 32'h0000003F, {26'h0000000, CFG.port_a_dir});
    foreach (RI[i]) if (i > 4 && i < 8 || i == 1 || i == 12) wr(RI[i], 8'h00);
    wr(8'h83, 8'h25);
    wr(8'h84, 8'h55);
    WDT_TIMEOUT <= 1'b1;
    cyc(1);
    WDT_TIMEOUT <= 1'b0;
    cyc(1);
    rc_row(2);
    chk_pc(13'h0000);
    chk32("cfg_option", 32'h000000FF, {24'h000000, CFG.option});
    wr(8'h81, 8'h00);
    wr(8'h83, 8'h22);
    EXT_RESET_N <= 1'b0;
    cyc(4);
    EXT_RESET_N <= 1'b1;
    cyc(4);
    rc(8'h81, 8'hFF);
    rc(8'h83, 8'h0A);
    rc(8'h84, 8'h55);
    rc(8'h8E, 8'h03);
    wr(8'h81, 8'h00);
    BROWN_OUT <= 1'b1;
    cyc(4);
    BROWN_OUT <= 1'b0;
    cyc(4);
    rc_row(3);
    wr(8'h0A, 8'h15);
    @(negedge CLK_SYS);
    chk_pc(13'h0000);
    @(posedge CLK_SYS);
    rc(8'h8A, 8'h15);
    wr(8'h02, 8'h34);
    @(negedge CLK_SYS);
    chk_pc(13'h1534);
    @(posedge CLK_SYS);
    PC_INC <= 1'b1;
    cyc(1);
    PC_INC <= 1'b0;
    @(negedge CLK_SYS);
    chk_pc(13'h1535);
    @(posedge CLK_SYS);
    rc(8'h82, 8'h35);
    rc(8'h01, 8'h00);
    wr(8'h04, 8'h81);
    wr(8'h80, 8'h5A);
    rc(8'h81, 8'h5A);
    rc(8'h00, 8'h5A);
    rc(8'h84, 8'h81);
    rc(8'h03, 8'h18);
    end_of_test();
  end
endmodule // tb_top
